// File: hdl/mpks_sequencer.sv
// Top of the power key sequencer, the module's own side.
// Turns a long key hold into power-on, a shorter one or a command into a
// network detach and power-off, and shows the result on power-good.
// Assumes key input is synchronous to ref_clk and already resolved from
// the open-collector wire; host pulls it low only.
// Assumes the network side answers a detach request with detach_done.
`timescale 1ns/1ps
module mpks_sequencer #(
	parameter int unsigned ON_HOLD_CYC  = mpks_pkg::ON_HOLD_CYC,
	parameter int unsigned OFF_HOLD_CYC = mpks_pkg::OFF_HOLD_CYC
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic power_key_n,
	input  wire logic software_shutdown_command,
	input  wire logic detach_done,
	output logic      power_good_monitor,
	output logic      detach_request
);
	// Counter width shared with the hold timer
	localparam int unsigned W = mpks_pkg::CNT_W;

	mpks_pkg::mpks_state_t state_r;   // Current power state
	mpks_pkg::mpks_state_t state_nxt; // Next power state
	logic                  pg_nxt;    // Next power-good
	logic                  det_nxt;   // Next detach request
	logic                  rel_wait_r;   // Power-on hold done, key not yet let go
	logic                  rel_wait_nxt; // Next release wait
	logic                  power_up;     // Power-on hold completes this cycle

	mpks_hold_if #(.CNT_W(W)) hif ();

	// Key low seen as a level; limit depends on direction.
	// After power-on the timer stays parked at zero until the key is let
	// go, so one long press cannot arm power-off straight away.
	assign hif.key_low = !power_key_n && !rel_wait_r;
	// Power-on hold while off, the shorter power-off hold otherwise
	assign hif.limit   = (state_r == mpks_pkg::MPKS_OFF) ?
	                     W'(ON_HOLD_CYC) : W'(OFF_HOLD_CYC);

	mpks_hold_timer #(.CNT_W(W)) u_timer (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.hif     (hif)
	);

	// Power-on completes on the edge where the long hold is reached
	assign power_up     = (state_r == mpks_pkg::MPKS_OFF) && hif.reached;
	// Set on power-on, cleared once the host lets the key go; the set
	// cannot meet the clear since power-on needs the key held low
	assign rel_wait_nxt = power_up ? 1'b1 : (power_key_n ? 1'b0 : rel_wait_r);

	// Release-wait register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			// Nothing held at start
			rel_wait_r <= 1'b0;
		end else begin
			rel_wait_r <= rel_wait_nxt;
		end
	end

	// State walk:
	//   OFF    - power-good low; a full power-on hold moves to ON
	//   ON     - power-good high; command goes to DETACH, a full
	//            power-off hold goes to ARMED
	//   ARMED  - power-off hold met; waits for the key to be let go
	//   DETACH - detach request high; waits for the network answer
	// Short presses restart the timer and never leave a state.
	// A command seen outside ON is dropped, not remembered.

	// Next-state decode
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mpks_pkg::MPKS_OFF: begin
				// Power-on once the long hold is complete
				if (hif.reached) begin
					state_nxt = mpks_pkg::MPKS_ON;
				end
			end
			mpks_pkg::MPKS_ON: begin
				// Either trigger leads toward shutdown
				if (software_shutdown_command) begin
					state_nxt = mpks_pkg::MPKS_DETACH;
				end else if (hif.reached) begin
					state_nxt = mpks_pkg::MPKS_ARMED;
				end
			end
			mpks_pkg::MPKS_ARMED: begin
				// Wait for release before shutting down
				if (power_key_n) begin
					state_nxt = mpks_pkg::MPKS_DETACH;
				end
			end
			mpks_pkg::MPKS_DETACH: begin
				// Off only after network detach completes
				if (detach_done) begin
					state_nxt = mpks_pkg::MPKS_OFF;
				end
			end
			default: begin
				state_nxt = mpks_pkg::MPKS_OFF;
			end
		endcase
	end

	// Outputs decoded from the coming state so they are registered
	assign pg_nxt  = (state_nxt != mpks_pkg::MPKS_OFF);
	assign det_nxt = (state_nxt == mpks_pkg::MPKS_DETACH);

	// State and output registers; outputs leave straight from flops
	// and reset puts the module off with nothing pending
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r            <= mpks_pkg::MPKS_OFF;
			power_good_monitor <= 1'b0;
			detach_request     <= 1'b0;
		end else begin
			state_r            <= state_nxt;
			power_good_monitor <= pg_nxt;
			detach_request     <= det_nxt;
		end
	end

	// Helper: cycles held low, for the assertions. It counts every low
	// edge, parked or not, so it never runs behind the hold timer and
	// the bounds below are safe lower limits. It stops at all ones.
	logic [W-1:0] low_cnt_r; // Consecutive low edges seen
	always_ff @(posedge ref_clk) begin
		if (!reset_n || power_key_n) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r != '1) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end

	// Detach answered: request seen, then power-good gone next edge
	sequence s_detach_then_off;
		detach_request ##1 !power_good_monitor;
	endsequence

	// Power-off hold met but key still pressed
	sequence s_armed_held;
		state_r == mpks_pkg::MPKS_ARMED && !power_key_n;
	endsequence

	// Module running, no detach under way
	sequence s_running_quiet;
		power_good_monitor && !detach_request;
	endsequence

	// Module off, nothing pending
	sequence s_off_quiet;
		!power_good_monitor && !detach_request;
	endsequence

	// Checks watch the registered outputs one edge after the cause.
	// The hold bounds use low_cnt_r, which sees the whole press, so a
	// short press can never satisfy them by accident.

	chk_on_needs_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(power_good_monitor) |-> $past(low_cnt_r) >= W'(ON_HOLD_CYC - 1))
		else $error("power-good rose without full hold");
	chk_pg_rises_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_OFF && hif.reached) |=> power_good_monitor)
		else $error("power-good did not rise after hold");
	chk_off_after_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_armed_held |=> s_running_quiet)
		else $error("shutdown began while key held");
	chk_detach_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(power_good_monitor) |-> $past(detach_request))
		else $error("off without detach request");
	chk_pg_falls_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(detach_request && detach_done) |=> !power_good_monitor && !detach_request)
		else $error("power-good did not fall");
	chk_sw_shutdown: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_ON && software_shutdown_command) |=> detach_request)
		else $error("software shutdown ignored");
	chk_short_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_ON && low_cnt_r < W'(OFF_HOLD_CYC - 1)
		 && !software_shutdown_command) |=> state_r == mpks_pkg::MPKS_ON)
		else $error("short pulse changed state");
	chk_off_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(state_r == mpks_pkg::MPKS_ARMED) |-> $past(low_cnt_r) >= W'(OFF_HOLD_CYC - 1))
		else $error("off armed before full hold");
	chk_detach_seq: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(detach_request && detach_done) |-> s_detach_then_off)
		else $error("detach sequence broken");

	// Letting go of an armed key starts the detach on the next edge
	chk_release_detach: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_ARMED && power_key_n) |=> detach_request)
		else $error("release did not start shutdown");

	// A power-on hold kept past the off limit leaves the module on
	chk_long_hold_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_ON && rel_wait_r && !software_shutdown_command)
		|=> state_r == mpks_pkg::MPKS_ON)
		else $error("power-on hold armed power-off");

	// Running module stays up while no trigger is met
	chk_pg_stays_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_ON && !software_shutdown_command && !hif.reached)
		|=> s_running_quiet)
		else $error("power-good dropped while running");

	// Module that is off stays quiet until a full hold
	chk_stays_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_OFF && !hif.reached) |=> s_off_quiet)
		else $error("outputs rose while off");

	// Short presses while off change nothing
	chk_short_on_ign: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_r == mpks_pkg::MPKS_OFF && low_cnt_r < W'(ON_HOLD_CYC - 1))
		|=> state_r == mpks_pkg::MPKS_OFF)
		else $error("short pulse powered on");

	// Detach is asked for while the module is still up
	chk_detach_while_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		detach_request |-> power_good_monitor)
		else $error("detach request with power-good low");
endmodule

// File: hdl/mpks_pkg.sv
// Constants and state type for the power key sequencer.
// Assumes a single 125 MHz clock; all times are counted on it.
// Functional notes
// - Power-good rises once power-on completes
// - Power-off by command or long key pulse
// - Detach request precedes every shutdown
// - Hardware shutdown starts only after key release
// - Power-good falls once module is off
package mpks_pkg;
	// Clock rate in kHz
	localparam int unsigned CLK_KHZ        = 125000;
	// Minimum hold for power-on, ms
	localparam int unsigned ON_HOLD_MS     = 5000;
	// Minimum hold for power-off, ms
	localparam int unsigned OFF_HOLD_MS    = 2000;
	// Derived cycle counts (least times, exact here)
	localparam int unsigned ON_HOLD_CYC    = ON_HOLD_MS * CLK_KHZ;
	localparam int unsigned OFF_HOLD_CYC   = OFF_HOLD_MS * CLK_KHZ;
	// Counter width covering the longest hold
	localparam int unsigned CNT_W          = 30;
	// Power state machine, one-hot
	typedef enum logic [3:0] {
		MPKS_OFF    = 4'h1,
		MPKS_ON     = 4'h2,
		MPKS_ARMED  = 4'h4,
		MPKS_DETACH = 4'h8
	} mpks_state_t;
endpackage

// File: hdl/mpks_hold_if.sv
// Carrier between the sequencer and its hold timer.
// Assumes both ends sit on ref_clk.
`timescale 1ns/1ps
interface mpks_hold_if #(parameter int unsigned CNT_W = 30);
	logic             key_low;   // Key line seen low
	logic [CNT_W-1:0] limit;     // Hold length to reach
	logic             reached;   // Held at least limit cycles
	modport timer (input key_low, input limit, output reached);
	modport ctrl  (output key_low, output limit, input reached);
endinterface

// File: hdl/mpks_hold_timer.sv
// Hold timer: measures a continuous low on the key line.
// Assumes synchronous inputs and a synchronous active-low reset.
`timescale 1ns/1ps
module mpks_hold_timer #(
	parameter int unsigned CNT_W = 30
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	mpks_hold_if.timer hif
);
	logic [CNT_W-1:0] cnt_r;   // Cycles held low so far
	logic [CNT_W-1:0] cnt_nxt; // Next count
	logic             sat;     // Limit reached

	assign sat     = (cnt_r >= hif.limit);
	// Restart on any release so short pulses never add up
	assign cnt_nxt = !hif.key_low ? '0 : (sat ? cnt_r : cnt_r + 1'b1);
	assign hif.reached = sat && hif.key_low;

	// Count register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// File: dv/mpks_host_model.sv
// Host partner: open-collector key drive and network detach answer.
// Assumes it shares ref_clk with the sequencer.
`timescale 1ns/1ps
module mpks_host_model (
	input  wire logic ref_clk,
	input  wire logic key_pull,
	input  wire logic detach_request,
	output logic      power_key_n,
	output logic      detach_done
);
	logic [3:0] wait_r; // Detach reply delay
	// Pull-down only; internal pull-up gives the high level
	assign power_key_n = key_pull ? 1'b0 : 1'b1;
	// Network finishes detach a few cycles after request
	always_ff @(posedge ref_clk) begin
		wait_r      <= detach_request ? wait_r + 4'h1 : 4'h0;
		detach_done <= (wait_r == 4'h5);
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the power key sequencer.
// Assumes short hold parameters and a host model on the far side.
`timescale 1ns/1ps
module tb;
	localparam int unsigned ON_C  = 20; // Short power-on hold
	localparam int unsigned OFF_C = 10; // Short power-off hold
	localparam int unsigned QUIET_C = 8; // Settle time before a command
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic key_pull = 1'b0; // Host pulls key low
	logic cmd = 1'b0;      // Shutdown command, idles low
	logic key_n, done, pg, dreq;
	int   mismatches = 0;
	int   tests_run = 0;
	always #4 ref_clk = ~ref_clk;
	mpks_sequencer #(.ON_HOLD_CYC(ON_C), .OFF_HOLD_CYC(OFF_C)) u_mpks_sequencer (
		.ref_clk(ref_clk), .reset_n(reset_n), .power_key_n(key_n),
		.software_shutdown_command(cmd), .detach_done(done),
		.power_good_monitor(pg), .detach_request(dreq));
	mpks_host_model u_mpks_host_model (.ref_clk(ref_clk), .key_pull(key_pull),
		.detach_request(dreq), .power_key_n(key_n), .detach_done(done));
	// Verdict and end of run
	task automatic close_out();
		if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Compare one output bit
	task automatic chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Hold key low n cycles, then release
	task automatic press(input int n);
		@(negedge ref_clk) key_pull = 1'b1;
		repeat (n) @(negedge ref_clk);
		key_pull = 1'b0;
	endtask
	// Bounded wait for power-good (0) or detach (1) to reach v
	task automatic wait_sig(input int sel, input logic v);
		for (int i = 0; i < 40; i++) begin
			if (((sel == 0) ? pg : dreq) === v) break;
			@(negedge ref_clk);
		end
		chk((sel == 0) ? pg : dreq, v);
	endtask
	// Short press while off leaves module off
	task automatic t_short_on();
		press(ON_C - 5);
		repeat (4) @(negedge ref_clk);
		chk(pg, 1'b0);
	endtask
	// Long press powers on
	task automatic t_power_on();
		press(ON_C + OFF_C + 2); // Held past both limits
		wait_sig(0, 1'b1);
		repeat (4) @(negedge ref_clk);
		chk(dreq, 1'b0);
	endtask
	// Short press while on is ignored
	task automatic t_short_off();
		press(OFF_C - 4);
		repeat (4) @(negedge ref_clk);
		chk(dreq, 1'b0);
		chk(pg, 1'b1);
	endtask
	// Key-driven off: detach only after release, then power-good low
	task automatic t_key_off();
		@(negedge ref_clk) key_pull = 1'b1;
		repeat (OFF_C + 4) @(negedge ref_clk);
		chk(dreq, 1'b0);
		key_pull = 1'b0;
		wait_sig(1, 1'b1);
		chk(pg, 1'b1);
		wait_sig(0, 1'b0);
	endtask
	// Command-driven off; command while off ignored
	task automatic t_cmd_off();
		@(negedge ref_clk) cmd = 1'b1;
		@(negedge ref_clk) cmd = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(dreq, 1'b0);
		t_power_on();
		repeat (QUIET_C) @(negedge ref_clk);
		@(negedge ref_clk) cmd = 1'b1;
		@(negedge ref_clk) cmd = 1'b0;
		wait_sig(1, 1'b1);
		chk(pg, 1'b1);
		wait_sig(0, 1'b0);
	endtask
	// Watchdog
	initial begin
		#20000;
		mismatches++;
		close_out();
	end
	// Main sequence
	initial begin
		repeat (2) @(negedge ref_clk);
		reset_n = 1'b1;
		chk(pg, 1'b0);
		t_short_on();
		t_power_on();
		t_short_off();
		t_key_off();
		t_cmd_off();
		close_out();
	end
endmodule
